/* File: rtl/uart_lmcs_pkg.sv */
// Shared constants and types for the line, modem control and status block
`default_nettype none
package uart_lmcs_pkg;
	localparam logic [7:0] OFS_DATA = 8'h00;
	localparam logic [7:0] OFS_IEN = 8'h04;
	localparam logic [7:0] OFS_EFR = 8'h08;
	localparam logic [7:0] OFS_LCTL = 8'h0C;
	localparam logic [7:0] OFS_MCTL = 8'h10;
	localparam logic [7:0] OFS_LSTAT = 8'h14;
	localparam logic [7:0] LCTL_RST = 8'h00;
	localparam logic [7:0] MCTL_RST = 8'h00;
	localparam logic [7:0] IEN_RST = 8'h00;
	localparam logic [7:0] EFR_RST = 8'h00;
	localparam logic [15:0] DIV_RST = 16'h0001;
	localparam logic [5:0] SYNC_RST = 6'h1F;
	localparam int LC_STOP = 2;
	localparam int LC_PEN = 3;
	localparam int LC_EVEN = 4;
	localparam int LC_FORCE = 5;
	localparam int LC_BRK = 6;
	localparam int LC_DLAB = 7;
	localparam int MC_DTR = 0;
	localparam int MC_RTS = 1;
	localparam int MC_OUT1 = 2;
	localparam int MC_IRQEN = 3;
	localparam int MC_LOOP = 4;
	localparam int MC_ANY = 5;
	localparam int MC_IR = 6;
	localparam int MC_PRESC = 7;
	localparam int EF_ENH = 4;
	localparam int EF_ARTS = 6;
	localparam int IE_LS = 2;
	localparam logic [5:0] BIT_T = 6'h10;
	localparam logic [5:0] MID_T = 6'h08;
	localparam logic [5:0] STOP15_T = 6'h18;
	localparam logic [5:0] STOP2_T = 6'h20;
	localparam logic [5:0] IR_PULSE_T = 6'h03;
	localparam logic [1:0] PRESC_LAST = 2'h3;
	typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP, ST_WAIT} ser_state_t;
	typedef struct packed {
		logic cd;
		logic ri;
		logic dsr;
		logic cts;
	} modem_t;
	typedef struct packed {
		logic [7:0] data;
		logic pe;
		logic fe;
		logic bi;
	} rxchar_t;
endpackage : uart_lmcs_pkg
`default_nettype wire

/* File: rtl/uart_line_modem_ctrl_status.sv */
// One serial channel: format control, modem control outputs, line status
// Summary of operation
// - Two-bit field selects five to eight bits
// - Stop select gives 1, 1.5 or 2
// - Parity enable adds and checks parity bit
// - Parity type picks odd or even
// - Forced parity gives fixed mark or space
// - Break bit holds transmit line low outside loopback and infrared modes
// - Divisor access bit redirects shared addresses
// - Terminal-ready bit drives low-active output
// - Send-request bit drives low-active output
// - User output one feeds loopback ring
// - Interrupt output enable and user output two
// - Loopback bit enables internal local loopback
// - Any character resumes suspended transmission
// - Infrared coding, transmit low when idle
// - Prescaler divides clock by four
// - Line status interrupt from error flags
// - Receive ready while a character held
// - Overrun flagged, held data kept intact
// - Parity and framing follow held character
// - Break stored once, held until high
// - Holding-empty set on move, cleared on write
// - Loopback feeds modem status from control
// - Line status read clears its interrupt
`default_nettype none
module uart_line_modem_ctrl_status #(
	parameter logic [7:0] XON_CHAR = 8'h11,
	parameter logic [7:0] XOFF_CHAR = 8'h13
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rxPin,
	output logic txPin,
	output logic irTxPin,
	input wire logic ctsN,
	input wire logic dsrN,
	input wire logic riN,
	input wire logic cdN,
	output logic dtrN,
	output logic rtsN,
	input wire logic irqOutputSelectPin,
	output logic irqOut,
	output logic irqOeN,
	input wire logic txSuspendReq,
	output uart_lmcs_pkg::modem_t modemState
);
	logic [7:0] lcr_r, mcr_r, ien_r, efr_r, divLo_r, divHi_r, thr_r;
	logic thrEmpty_r, rxFull_r, ovr_r, lsIrq_r, suspended_r;
	uart_lmcs_pkg::rxchar_t rxHold_r;
	logic [31:0] prdata_r;
	logic [5:0] syncIn, s1_r, s2_r, s3_r, filt_r;

	// Three-stage input synchronisers with agreement filter
	assign syncIn = {irqOutputSelectPin, cdN, riN, dsrN, ctsN, rxPin};
	genvar gi;
	for (gi = 0; gi < 6; gi++) begin : g_sync
		always_ff @(posedge core_clk or negedge resetn) begin
			if (!resetn) begin
				s1_r[gi] <= uart_lmcs_pkg::SYNC_RST[gi];
				s2_r[gi] <= uart_lmcs_pkg::SYNC_RST[gi];
				s3_r[gi] <= uart_lmcs_pkg::SYNC_RST[gi];
				filt_r[gi] <= uart_lmcs_pkg::SYNC_RST[gi];
			end else begin
				s1_r[gi] <= syncIn[gi];
				s2_r[gi] <= s1_r[gi];
				s3_r[gi] <= s2_r[gi];
				if (s2_r[gi] == s3_r[gi]) begin
					filt_r[gi] <= s3_r[gi];
				end
			end
		end
	end

	// Bus decode
	wire [7:0] addr = paddr[7:0];
	wire mapped = (paddr[31:8] == 24'h0000_00) && (paddr[1:0] == 2'h0)
		&& (addr <= uart_lmcs_pkg::OFS_LSTAT);
	wire apbSetup = psel && !penable;
	wire apbAcc = psel && penable;
	wire wr = apbAcc && pwrite && mapped;
	wire rd = apbAcc && !pwrite && mapped;
	wire dlab = lcr_r[uart_lmcs_pkg::LC_DLAB];
	wire atData = addr == uart_lmcs_pkg::OFS_DATA;
	wire atIen = addr == uart_lmcs_pkg::OFS_IEN;
	wire wThr = wr && atData && !dlab;
	wire wDivLo = wr && atData && dlab;
	wire wDivHi = wr && atIen && dlab;
	wire wIen = wr && atIen && !dlab;
	wire wEfr = wr && addr == uart_lmcs_pkg::OFS_EFR;
	wire wLcr = wr && addr == uart_lmcs_pkg::OFS_LCTL;
	wire wMcr = wr && addr == uart_lmcs_pkg::OFS_MCTL;
	wire rRhr = rd && atData && !dlab;
	wire rLsr = rd && addr == uart_lmcs_pkg::OFS_LSTAT;
	assign pready = 1'b1;
	assign pslverr = apbAcc && !mapped;
	assign prdata = prdata_r;

	// Mode decode
	wire enh = efr_r[uart_lmcs_pkg::EF_ENH];
	wire loop = mcr_r[uart_lmcs_pkg::MC_LOOP];
	wire irMode = enh && mcr_r[uart_lmcs_pkg::MC_IR];
	wire presc = enh && mcr_r[uart_lmcs_pkg::MC_PRESC];
	wire xonAny = enh && mcr_r[uart_lmcs_pkg::MC_ANY];
	wire brk = lcr_r[uart_lmcs_pkg::LC_BRK];
	wire parEn = lcr_r[uart_lmcs_pkg::LC_PEN];
	wire [3:0] dataBits = 4'h5 + {2'h0, lcr_r[1:0]};
	wire [7:0] dataMask = ~(8'hFF << dataBits);
	wire [5:0] stopTicks = !lcr_r[uart_lmcs_pkg::LC_STOP] ? uart_lmcs_pkg::BIT_T
		: (lcr_r[1:0] == 2'h0) ? uart_lmcs_pkg::STOP15_T : uart_lmcs_pkg::STOP2_T;

	function automatic logic parityOf(input logic [7:0] d, input logic [7:0] lc);
		logic p;
		p = 1'b0;
		if (lc[uart_lmcs_pkg::LC_FORCE]) begin
			p = !lc[uart_lmcs_pkg::LC_EVEN];
		end else begin
			p = lc[uart_lmcs_pkg::LC_EVEN] ? ^d : ~^d;
		end
		return p;
	endfunction : parityOf

	// Baud tick, optionally after a divide-by-four prescaler
	logic [1:0] preCnt_r;
	logic [15:0] baudCnt_r;
	wire preTick = !presc || preCnt_r == uart_lmcs_pkg::PRESC_LAST;
	wire tick = preTick && baudCnt_r <= 16'h0001;
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			preCnt_r <= 2'h0;
			baudCnt_r <= uart_lmcs_pkg::DIV_RST;
		end else begin
			preCnt_r <= preCnt_r + 2'h1;
			if (preTick) begin
				baudCnt_r <= tick ? {divHi_r, divLo_r} : baudCnt_r - 16'h0001;
			end
		end
	end

	// Transmitter
	uart_lmcs_pkg::ser_state_t txSt_r;
	logic [7:0] txShift_r;
	logic txPar_r, txPin_r, irTx_r;
	logic [2:0] txBit_r;
	logic [5:0] txTick_r;
	wire txLoad = txSt_r == uart_lmcs_pkg::ST_IDLE && !thrEmpty_r && !suspended_r;
	wire txLast = txTick_r == ((txSt_r == uart_lmcs_pkg::ST_STOP) ? stopTicks - 6'h01
		: uart_lmcs_pkg::BIT_T - 6'h01);
	wire txLastBit = {1'b0, txBit_r} == dataBits - 4'h1;
	logic txLevel;
	always_comb begin
		unique case (txSt_r)
			uart_lmcs_pkg::ST_START: txLevel = 1'b0;
			uart_lmcs_pkg::ST_DATA: txLevel = txShift_r[0];
			uart_lmcs_pkg::ST_PAR: txLevel = txPar_r;
			default: txLevel = 1'b1;
		endcase
	end
	wire serOut = brk ? 1'b0 : txLevel;
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			txSt_r <= uart_lmcs_pkg::ST_IDLE;
			txShift_r <= 8'h00;
			txPar_r <= 1'b0;
			txBit_r <= 3'h0;
			txTick_r <= 6'h00;
		end else if (txLoad) begin
			txShift_r <= thr_r & dataMask;
			txPar_r <= parityOf(thr_r & dataMask, lcr_r);
			txSt_r <= uart_lmcs_pkg::ST_START;
			txTick_r <= 6'h00;
			txBit_r <= 3'h0;
		end else if (tick && txSt_r != uart_lmcs_pkg::ST_IDLE) begin
			txTick_r <= txLast ? 6'h00 : txTick_r + 6'h01;
			if (txLast) begin
				unique case (txSt_r)
					uart_lmcs_pkg::ST_START: txSt_r <= uart_lmcs_pkg::ST_DATA;
					uart_lmcs_pkg::ST_DATA: begin
						txShift_r <= txShift_r >> 1;
						txBit_r <= txBit_r + 3'h1;
						if (txLastBit) begin
							txSt_r <= parEn ? uart_lmcs_pkg::ST_PAR : uart_lmcs_pkg::ST_STOP;
						end
					end
					uart_lmcs_pkg::ST_PAR: txSt_r <= uart_lmcs_pkg::ST_STOP;
					default: txSt_r <= uart_lmcs_pkg::ST_IDLE;
				endcase
			end
		end
	end
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			txPin_r <= 1'b1;
			irTx_r <= 1'b0;
		end else begin
			txPin_r <= loop || irMode || serOut;
			irTx_r <= irMode && !loop && !serOut && txTick_r < uart_lmcs_pkg::IR_PULSE_T;
		end
	end
	assign txPin = txPin_r;
	assign irTxPin = irTx_r;

	// Receiver
	logic [3:0] irStretch_r;
	wire rxF = filt_r[0];
	wire irDec = !(rxF || irStretch_r != 4'h0);
	wire rxIn = loop ? serOut : (irMode ? irDec : rxF);
	uart_lmcs_pkg::ser_state_t rxSt_r;
	logic [7:0] rxShift_r;
	logic [2:0] rxBit_r;
	logic [5:0] rxTick_r;
	logic rxPar_r, rxZero_r;
	wire rxSample = tick && rxTick_r == uart_lmcs_pkg::BIT_T - 6'h01;
	wire rxMid = tick && rxTick_r == uart_lmcs_pkg::MID_T - 6'h01;
	wire rxDone = rxSample && rxSt_r == uart_lmcs_pkg::ST_STOP;
	wire rxLastBit = {1'b0, rxBit_r} == dataBits - 4'h1;
	wire [7:0] rxData = (rxShift_r >> (4'h8 - dataBits)) & dataMask;
	wire rxBi = rxZero_r && !rxIn;
	wire rxFe = !rxIn;
	wire rxPe = parEn && rxPar_r != parityOf(rxData, lcr_r);
	wire isFlow = efr_r[3:0] != 4'h0 && (rxData == XON_CHAR || rxData == XOFF_CHAR);
	wire store = rxDone && !(isFlow && !rxBi);
	wire rxLoad = store && (!rxFull_r || rRhr);
	wire ovrEvt = store && rxFull_r && !rRhr;
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			irStretch_r <= 4'h0;
		end else if (rxF) begin
			irStretch_r <= 4'hF;
		end else if (tick && irStretch_r != 4'h0) begin
			irStretch_r <= irStretch_r - 4'h1;
		end
	end
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rxSt_r <= uart_lmcs_pkg::ST_IDLE;
			rxShift_r <= 8'h00;
			rxBit_r <= 3'h0;
			rxTick_r <= 6'h00;
			rxPar_r <= 1'b0;
			rxZero_r <= 1'b0;
		end else begin
			if (tick) begin
				rxTick_r <= rxSample || rxMid && rxSt_r == uart_lmcs_pkg::ST_START ? 6'h00
					: rxTick_r + 6'h01;
			end
			unique case (rxSt_r)
				uart_lmcs_pkg::ST_IDLE: if (!rxIn) begin
					rxSt_r <= uart_lmcs_pkg::ST_START;
					rxTick_r <= 6'h00;
					rxBit_r <= 3'h0;
					rxZero_r <= 1'b1;
				end
				uart_lmcs_pkg::ST_START: if (rxMid) begin
					rxSt_r <= rxIn ? uart_lmcs_pkg::ST_IDLE : uart_lmcs_pkg::ST_DATA;
				end
				uart_lmcs_pkg::ST_DATA: if (rxSample) begin
					rxShift_r <= {rxIn, rxShift_r[7:1]};
					rxZero_r <= rxZero_r && !rxIn;
					rxBit_r <= rxBit_r + 3'h1;
					if (rxLastBit) begin
						rxSt_r <= parEn ? uart_lmcs_pkg::ST_PAR : uart_lmcs_pkg::ST_STOP;
					end
				end
				uart_lmcs_pkg::ST_PAR: if (rxSample) begin
					rxPar_r <= rxIn;
					rxZero_r <= rxZero_r && !rxIn;
					rxSt_r <= uart_lmcs_pkg::ST_STOP;
				end
				uart_lmcs_pkg::ST_STOP: if (rxSample) begin
					rxSt_r <= rxBi ? uart_lmcs_pkg::ST_WAIT : uart_lmcs_pkg::ST_IDLE;
				end
				uart_lmcs_pkg::ST_WAIT: if (rxIn) begin
					rxSt_r <= uart_lmcs_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Holding registers and status flags
	wire lsEvt = ovrEvt || rxLoad && (rxPe || rxFe || rxBi);
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rxHold_r <= '0;
			rxFull_r <= 1'b0;
			ovr_r <= 1'b0;
			lsIrq_r <= 1'b0;
			thr_r <= 8'h00;
			thrEmpty_r <= 1'b1;
			suspended_r <= 1'b0;
		end else begin
			if (rxLoad) begin
				rxHold_r <= '{data: rxBi ? 8'h00 : rxData, pe: rxPe, fe: rxFe, bi: rxBi};
			end
			rxFull_r <= rxLoad || (rxFull_r && !rRhr);
			ovr_r <= ovrEvt || (ovr_r && !rLsr);
			lsIrq_r <= lsEvt || (lsIrq_r && !rLsr);
			if (wThr) begin
				thr_r <= pwdata[7:0];
			end
			thrEmpty_r <= !wThr && (thrEmpty_r || txLoad);
			suspended_r <= txSuspendReq || (suspended_r && !(rxDone && xonAny));
		end
	end

	// Control registers
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			lcr_r <= uart_lmcs_pkg::LCTL_RST;
			mcr_r <= uart_lmcs_pkg::MCTL_RST;
			ien_r <= uart_lmcs_pkg::IEN_RST;
			efr_r <= uart_lmcs_pkg::EFR_RST;
			divLo_r <= uart_lmcs_pkg::DIV_RST[7:0];
			divHi_r <= uart_lmcs_pkg::DIV_RST[15:8];
		end else begin
			if (wLcr) lcr_r <= pwdata[7:0];
			if (wMcr) mcr_r <= pwdata[7:0];
			if (wIen) ien_r <= pwdata[7:0];
			if (wEfr) efr_r <= pwdata[7:0];
			if (wDivLo) divLo_r <= pwdata[7:0];
			if (wDivHi) divHi_r <= pwdata[7:0];
		end
	end

	// Read path, captured in the setup phase
	wire [7:0] lsrVal = {rxFull_r && (rxHold_r.pe || rxHold_r.fe || rxHold_r.bi),
		thrEmpty_r && txSt_r == uart_lmcs_pkg::ST_IDLE, thrEmpty_r,
		rxHold_r.bi && rxFull_r, rxHold_r.fe && rxFull_r, rxHold_r.pe && rxFull_r,
		ovr_r, rxFull_r};
	wire [7:0] rdMux = atData ? (dlab ? divLo_r : rxHold_r.data)
		: atIen ? (dlab ? divHi_r : ien_r)
		: addr == uart_lmcs_pkg::OFS_EFR ? efr_r
		: addr == uart_lmcs_pkg::OFS_LCTL ? lcr_r
		: addr == uart_lmcs_pkg::OFS_MCTL ? mcr_r
		: addr == uart_lmcs_pkg::OFS_LSTAT ? lsrVal : 8'h00;
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			prdata_r <= 32'h0000_0000;
		end else if (apbSetup && !pwrite) begin
			prdata_r <= {24'h0000_00, mapped ? rdMux : 8'h00};
		end
	end

	// Modem and interrupt outputs
	uart_lmcs_pkg::modem_t mdm, modem_r;
	logic dtrN_r, rtsN_r, irq_r, irqOeN_r;
	wire autoRtsOff = efr_r[uart_lmcs_pkg::EF_ARTS] && rxFull_r;
	always_comb begin
		if (loop) begin
			mdm.cts = mcr_r[uart_lmcs_pkg::MC_RTS];
			mdm.dsr = mcr_r[uart_lmcs_pkg::MC_DTR];
			mdm.ri = mcr_r[uart_lmcs_pkg::MC_OUT1];
			mdm.cd = mcr_r[uart_lmcs_pkg::MC_IRQEN];
		end else begin
			mdm.cts = !filt_r[1];
			mdm.dsr = !filt_r[2];
			mdm.ri = !filt_r[3];
			mdm.cd = !filt_r[4];
		end
	end
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			modem_r <= '0;
			dtrN_r <= 1'b1;
			rtsN_r <= 1'b1;
			irq_r <= 1'b0;
			irqOeN_r <= 1'b1;
		end else begin
			modem_r <= mdm;
			dtrN_r <= loop || !mcr_r[uart_lmcs_pkg::MC_DTR];
			rtsN_r <= loop || !mcr_r[uart_lmcs_pkg::MC_RTS] || autoRtsOff;
			irq_r <= (ien_r[0] && rxFull_r) || (ien_r[1] && thrEmpty_r)
				|| (ien_r[uart_lmcs_pkg::IE_LS] && lsIrq_r);
			irqOeN_r <= !(filt_r[5] || mcr_r[uart_lmcs_pkg::MC_IRQEN]);
		end
	end
	assign modemState = modem_r;
	assign dtrN = dtrN_r;
	assign rtsN = rtsN_r;
	assign irqOut = irq_r;
	assign irqOeN = irqOeN_r;

	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	a_break_low: assert property (brk && $past(brk) |-> !txPin)
		else $error("break did not hold line low");
	a_dtr_follow: assert property (!loop && $past(!loop) |-> dtrN == !$past(mcr_r[0]))
		else $error("terminal ready output wrong");
	a_thr_write: assert property (wThr |=> !thrEmpty_r)
		else $error("holding empty not cleared by write");
	a_ovr_set: assert property (ovrEvt |=> ovr_r && rxHold_r == $past(rxHold_r))
		else $error("overrun flag or held data wrong");
	a_rx_ready: assert property (rxLoad |=> rxFull_r)
		else $error("receive ready not set");
	a_lsr_clear: assert property (rLsr && !lsEvt |=> !lsIrq_r)
		else $error("line status interrupt not cleared");
	a_presc_gap: assert property (presc && tick |=> !tick [*3])
		else $error("prescaler gap too short");
	a_ir_idle: assert property (irMode && txSt_r == uart_lmcs_pkg::ST_IDLE && !brk
		##1 irMode |-> !irTxPin)
		else $error("infrared output not low at idle");
	a_irq_oe: assert property (##1 irqOeN == !$past(filt_r[5] || mcr_r[3]))
		else $error("interrupt output enable wrong");
endmodule : uart_line_modem_ctrl_status
`default_nettype wire

/* File: verif/uart_remote_peer.sv */
// Far-end serial station: sends frames on the receive line, samples the transmit line
`default_nettype none
module uart_remote_peer #(
	parameter int BIT_CYC = 16
) (
	input wire logic clk,
	input wire logic txLine,
	output var logic rxLine
);
	timeunit 1ns;
	timeprecision 1ns;
	longint cyc = 0;
	initial rxLine = 1'b1;
	always @(posedge clk) begin
		cyc <= cyc + 1;
	end
	// Bits leave least significant first, line returns to mark after
	task automatic sendBits(input logic [11:0] bits, input int n);
		for (int i = 0; i < n; i++) begin
			rxLine <= bits[i];
			repeat (BIT_CYC) @(posedge clk);
		end
		rxLine <= 1'b1;
	endtask : sendBits
	task automatic holdLow(input int n);
		rxLine <= 1'b0;
		repeat (n) @(posedge clk);
		rxLine <= 1'b1;
	endtask : holdLow
	// Idle level differs in infrared mode
	task automatic setLevel(input logic v);
		rxLine <= v;
	endtask : setLevel
	// Samples n bits at mid-bit, start time in cycles
	task automatic capture(input int n, output logic [11:0] bits, output longint t0);
		int k = 0;
		bits = 12'h000;
		while (txLine !== 1'b0 && k < 4000) begin
			@(posedge clk);
			k++;
		end
		t0 = cyc;
		repeat (BIT_CYC / 2) @(posedge clk);
		for (int i = 0; i < n; i++) begin
			bits[i] = txLine;
			if (i < n - 1) repeat (BIT_CYC) @(posedge clk);
		end
	endtask : capture
endmodule : uart_remote_peer
`default_nettype wire

/* File: verif/uart_line_modem_ctrl_status_tb.sv */
// Self-checking bench for the line, modem control and status block
`default_nettype none
module uart_line_modem_ctrl_status_tb;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic [7:0] ctl; logic sel; logic [2:0] pins;} ctl_row_t;
	localparam logic [7:0] A_DATA = uart_lmcs_pkg::OFS_DATA;
	localparam logic [7:0] A_IEN = uart_lmcs_pkg::OFS_IEN;
	localparam logic [7:0] A_EFR = uart_lmcs_pkg::OFS_EFR;
	localparam logic [7:0] A_LINE = uart_lmcs_pkg::OFS_LCTL;
	localparam logic [7:0] A_MDM = uart_lmcs_pkg::OFS_MCTL;
	localparam logic [7:0] A_STAT = uart_lmcs_pkg::OFS_LSTAT;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000, prdata;
	logic pready, pslverr, rxPin, txPin, irTxPin, dtrN, rtsN, irqOut, irqOeN, errSeen;
	logic ctsN = 1'b1, dsrN = 1'b1, riN = 1'b1, cdN = 1'b1;
	logic irqSel = 1'b0;
	uart_lmcs_pkg::modem_t modemState;
	int n_fail = 0;
	int compares = 0;
	int nb, k;
	logic [31:0] rv;
	logic [11:0] fa, fb, fx, fy;
	longint ta, tb0;
	ctl_row_t rows[6] = '{'{8'h00, 1'b0, 3'h7}, '{8'h01, 1'b0, 3'h3}, '{8'h02, 1'b0, 3'h5},
		'{8'h08, 1'b0, 3'h6}, '{8'h00, 1'b1, 3'h6}, '{8'h0B, 1'b1, 3'h0}};
	logic [7:0] fmts[8] = '{8'h00, 8'h04, 8'h05, 8'h0B, 8'h1A, 8'h2B, 8'h3B, 8'h0F};
	always #20 core_clk = ~core_clk;
	uart_line_modem_ctrl_status dut_u (.core_clk(core_clk), .resetn(resetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rxPin(rxPin), .txPin(txPin), .irTxPin(irTxPin),
		.ctsN(ctsN), .dsrN(dsrN), .riN(riN), .cdN(cdN), .dtrN(dtrN), .rtsN(rtsN),
		.irqOutputSelectPin(irqSel), .irqOut(irqOut), .irqOeN(irqOeN), .txSuspendReq(1'b0),
		.modemState(modemState));
	uart_remote_peer peer_u (.clk(core_clk), .txLine(txPin), .rxLine(rxPin));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
		int n = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		paddr <= {24'h00_0000, a};
		pwrite <= w;
		pwdata <= {24'h00_0000, d};
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		// No answer within the limit counts as a failure
		if (pready !== 1'b1) n_fail++;
		rv = prdata;
		errSeen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		xfer(a, 1'b1, d);
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		xfer(a, 1'b0, 8'h00);
		chk(rv, {24'h00_0000, e});
	endtask : rdc
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask : cyc
	// Expected frame: start, data, parity if enabled, one stop; n gets the bit count
	function automatic logic [11:0] frameOf(input logic [7:0] lc, input logic [7:0] d,
		output int n);
		int wl;
		logic [11:0] f;
		wl = 5 + int'(lc[1:0]);
		d = d & (8'hFF >> (8 - wl));
		f = 12'h000;
		for (int i = 0; i < wl; i++) begin
			f[i + 1] = d[i];
		end
		n = wl + 1;
		if (lc[3]) begin
			f[n] = lc[5] ? ~lc[4] : (lc[4] ? ^d : ~^d);
			n++;
		end
		f[n] = 1'b1;
		n++;
		return f;
	endfunction : frameOf
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : complete_run
	initial begin
		repeat (40000) @(posedge core_clk);
		n_fail++;
		complete_run();
	end
	initial begin
		cyc(10);
		chk(32'({txPin, irTxPin, dtrN, rtsN, irqOut, irqOeN, modemState}), 32'h0000_02D0);
		resetn <= 1'b1;
		rdc(A_LINE, 8'h00);
		rdc(A_MDM, 8'h00);
		rdc(A_STAT, 8'h60);
		foreach (rows[i]) begin
			irqSel <= rows[i].sel;
			wr(A_MDM, rows[i].ctl);
			cyc(6);
			chk(32'({dtrN, rtsN, irqOeN}), 32'(rows[i].pins));
			rdc(A_MDM, rows[i].ctl);
		end
		irqSel <= 1'b0;
		ctsN <= 1'b0;
		riN <= 1'b0;
		cyc(8);
		chk(32'(modemState), 32'h0000_0005);
		ctsN <= 1'b1;
		riN <= 1'b1;
		foreach (fmts[i]) begin
			fx = frameOf(fmts[i], 8'hA6, nb);
			fy = frameOf(fmts[i], 8'h39, nb);
			k = !fmts[i][2] ? 16 : (fmts[i][1:0] == 2'h0 ? 24 : 32);
			fork
				begin
					peer_u.capture(nb, fa, ta);
					peer_u.capture(nb, fb, tb0);
				end
				begin
					wr(A_LINE, fmts[i]);
					wr(A_DATA, 8'hA6);
					wr(A_DATA, 8'h39);
					rdc(A_STAT, 8'h00);
				end
			join
			chk(32'(fa), 32'(fx));
			chk(32'(fb), 32'(fy));
			// One idle cycle before the queued character is loaded
			chk(32'(tb0 - ta), 32'(16 * (nb - 1) + k + 1));
			cyc(40);
		end
		wr(A_LINE, 8'h0B);
		wr(A_IEN, 8'h04);
		wr(A_MDM, 8'h08);
		fx = frameOf(8'h0B, 8'hA5, nb);
		peer_u.sendBits(fx, nb);
		cyc(40);
		rdc(A_STAT, 8'h61);
		rdc(A_DATA, 8'hA5);
		rdc(A_STAT, 8'h60);
		peer_u.sendBits(fx ^ 12'h200, nb);
		cyc(40);
		chk(32'(irqOut), 32'h1);
		rdc(A_STAT, 8'hE5);
		cyc(2);
		chk(32'(irqOut), 32'h0);
		rdc(A_DATA, 8'hA5);
		peer_u.sendBits(fx ^ 12'h400, nb);
		cyc(40);
		rdc(A_STAT, 8'hE9);
		rdc(A_DATA, 8'hA5);
		fx = frameOf(8'h0B, 8'h3C, nb);
		fy = frameOf(8'h0B, 8'hC3, nb);
		peer_u.sendBits(fx, nb);
		peer_u.sendBits(fy, nb);
		cyc(40);
		chk(32'(irqOut), 32'h1);
		rdc(A_STAT, 8'h63);
		cyc(2);
		chk(32'(irqOut), 32'h0);
		rdc(A_DATA, 8'h3C);
		wr(A_LINE, 8'h2B);
		fx = frameOf(8'h2B, 8'h5A, nb);
		peer_u.sendBits(fx, nb);
		cyc(40);
		rdc(A_STAT, 8'h61);
		rdc(A_DATA, 8'h5A);
		wr(A_LINE, 8'h0B);
		peer_u.holdLow(16 * 24);
		cyc(40);
		xfer(A_STAT, 1'b0, 8'h00);
		chk(rv & 32'h0000_0019, 32'h0000_0019);
		rdc(A_DATA, 8'h00);
		xfer(A_STAT, 1'b0, 8'h00);
		chk(32'(rv[0]), 32'h0);
		wr(A_LINE, 8'h4B);
		cyc(3);
		chk(32'(txPin), 32'h0);
		wr(A_LINE, 8'h0B);
		cyc(3);
		chk(32'(txPin), 32'h1);
		wr(A_LINE, 8'h8B);
		wr(A_IEN, 8'h00);
		rdc(A_IEN, 8'h00);
		wr(A_DATA, 8'h01);
		rdc(A_DATA, 8'h01);
		wr(A_LINE, 8'h0B);
		rdc(A_IEN, 8'h04);
		xfer(8'h18, 1'b0, 8'h00);
		chk({errSeen, rv[30:0]}, 32'h8000_0000);
		wr(A_STAT, 8'hFF);
		xfer(A_STAT, 1'b0, 8'h00);
		chk(rv & 32'h0000_0003, 32'h0000_0000);
		wr(A_MDM, 8'h1F);
		cyc(4);
		chk(32'({txPin, dtrN, rtsN, modemState}), 32'h0000_007F);
		wr(A_MDM, 8'h13);
		cyc(4);
		chk(32'(modemState), 32'h0000_0003);
		wr(A_DATA, 8'h5A);
		cyc(4);
		chk(32'(txPin), 32'h1);
		cyc(260);
		rdc(A_DATA, 8'h5A);
		wr(A_MDM, 8'h00);
		peer_u.setLevel(1'b0);
		wr(A_EFR, 8'h10);
		wr(A_MDM, 8'h40);
		cyc(4);
		chk(32'({txPin, irTxPin}), 32'h2);
		wr(A_DATA, 8'h00);
		k = 0;
		repeat (260) begin
			@(posedge core_clk);
			if (irTxPin === 1'b1) k++;
		end
		chk(k, 27);
		peer_u.setLevel(1'b1);
		wr(A_MDM, 8'h80);
		wr(A_DATA, 8'h55);
		k = 0;
		while (txPin !== 1'b0 && k < 400) begin
			@(posedge core_clk);
			k++;
		end
		k = 0;
		while (txPin === 1'b0 && k < 400) begin
			@(posedge core_clk);
			k++;
		end
		// Start bit depends on prescaler phase, so time the first data bit
		k = 0;
		while (txPin === 1'b1 && k < 400) begin
			@(posedge core_clk);
			k++;
		end
		chk(k, 64);
		cyc(800);
		complete_run();
	end
endmodule : uart_line_modem_ctrl_status_tb
`default_nettype wire
